// ==== wdrc_defines.vh ====
// Constants for the watchdog and reset-control block: offsets, fields, reset values, timing.
// Assumes inclusion by bare name from the block's design file.
`ifndef WDRC_DEFINES_VH
`define WDRC_DEFINES_VH

`define WDRC_OFS_DOG_CTRL     4'h0
`define WDRC_OFS_CAUSE        4'h1
`define WDRC_OFS_BROWNOUT     4'h2
`define WDRC_OFS_STATUS       4'h3

`define WDRC_DOG_CTRL_RST     8'h53
`define WDRC_BROWNOUT_RST     8'h5A
`define WDRC_KEY_ENABLE       5'h0A
`define WDRC_KEY_DISABLE      5'h15
`define WDRC_LVL_1V7          8'h5A
`define WDRC_LVL_OFF          8'hA5
`define WDRC_KEY_MSB          7
`define WDRC_KEY_LSB          3
`define WDRC_SEL_MSB          2
`define WDRC_SEL_LSB          0
`define WDRC_BIT_KEY_FAULT    0
`define WDRC_BIT_LVL_FAULT    1
`define WDRC_BIT_LOWVOLT      2
`define WDRC_BIT_EXPIRY       0
`define WDRC_BIT_POWER_DOWN   1
`define WDRC_PORT_RST         8'hFF

`define WDRC_SOFT_DELAY_CYC   16
`define WDRC_DEBOUNCE_NS      1000
`define WDRC_CLK_NS           40
`define WDRC_DEBOUNCE_CYC     ((`WDRC_DEBOUNCE_NS + `WDRC_CLK_NS - 1) / `WDRC_CLK_NS)

`endif

// ==== wdrc_watchdog_and_reset_control.v ====
// Watchdog timer, keyed brownout control and reset-cause flags of a small microcontroller.
// Assumes a 25 MHz clock, a synchronous slow-oscillator tick and a synchronous supply-low flag.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "wdrc_defines.vh"

module wdrc_watchdog_and_reset_control #(
  parameter SOFT_DELAY_CYC = `WDRC_SOFT_DELAY_CYC, // Soft reset delay in clock cycles.
  parameter DEBOUNCE_CYC   = `WDRC_DEBOUNCE_CYC    // Low-supply debounce in clock cycles.
) (
  input  wire       clock_i,         // System clock, 25 MHz.
  input  wire       nrst_i,          // Power-on reset, synchronous, active low.
  input  wire [3:0] addr_i,          // Register address.
  input  wire [7:0] wdata_i,         // Register write data.
  input  wire       wr_i,            // Write strobe.
  input  wire       rd_i,            // Read strobe.
  output reg  [7:0] rdata_o,         // Read data, valid the cycle after rd_i.
  input  wire       slow_tick_i,     // One pulse per slow internal oscillator cycle.
  input  wire       clr_dog_i,       // Watchdog clear instruction executed.
  input  wire       halt_i,          // Halt instruction executed, entering low power.
  input  wire       low_power_i,     // Device is in sleep or idle.
  input  wire       supply_low_i,    // Supply below the selected threshold.
  output wire       sys_reset_o,     // Full device reset pulse.
  output wire       pc_sp_reset_o,   // Program counter and stack pointer reset pulse.
  output wire       port_preset_o,   // Port data and direction registers to load all ones.
  output wire [7:0] port_reset_val_o,// Value for port data and direction registers.
  output wire       lowvolt_en_o,    // Low-voltage detection armed.
  output wire [7:0] brownout_level_o // Current level select.
);

  localparam ST_RUN   = 2'b00;
  localparam ST_DELAY = 2'b01;

  reg [7:0]  dog_ctrl_r;
  reg [7:0]  brownout_r;
  reg [2:0]  cause_r;
  reg        dog_expiry_flag_r;
  reg        power_down_flag_r;
  reg [15:0] dog_cnt_r;
  reg [1:0]  state_r;
  reg [15:0] delay_cnt_r;
  reg        pend_key_r;
  reg        pend_lvl_r;
  reg [15:0] deb_cnt_r;
  reg        sys_rst_r;
  reg        pcsp_rst_r;
  reg        por_r;

  function key_valid;
    input [4:0] k;
    begin
      key_valid = (k == `WDRC_KEY_ENABLE) || (k == `WDRC_KEY_DISABLE);
    end
  endfunction

  function lvl_valid;
    input [7:0] v;
    begin
      lvl_valid = (v == `WDRC_LVL_1V7) || (v == `WDRC_LVL_OFF);
    end
  endfunction

  wire [4:0] dog_key_field     = dog_ctrl_r[`WDRC_KEY_MSB:`WDRC_KEY_LSB];
  wire [2:0] dog_period_select = dog_ctrl_r[`WDRC_SEL_MSB:`WDRC_SEL_LSB];
  wire       dog_enabled       = (dog_key_field == `WDRC_KEY_ENABLE);
  wire       wr_dog            = wr_i && (addr_i == `WDRC_OFS_DOG_CTRL);
  wire       wr_cause          = wr_i && (addr_i == `WDRC_OFS_CAUSE);
  wire       wr_lvl            = wr_i && (addr_i == `WDRC_OFS_BROWNOUT);
  wire       key_bad_wr        = wr_dog && !key_valid(wdata_i[`WDRC_KEY_MSB:`WDRC_KEY_LSB]);
  wire       lvl_bad_wr        = wr_lvl && !lvl_valid(wdata_i);

  // Overflow tested against the boundary of the current select each tick.
  wire [15:0] dog_limit = 16'h0100 << dog_period_select;
  wire        dog_ovf   = dog_enabled && slow_tick_i && (dog_cnt_r + 16'h0001 >= dog_limit);

  // Detection only counts outside low power and with a 1.7V level selected.
  assign lowvolt_en_o = !low_power_i && (brownout_r == `WDRC_LVL_1V7);
  wire   lv_trip      = lowvolt_en_o && supply_low_i && (deb_cnt_r >= DEBOUNCE_CYC);

  wire soft_fire = (state_r == ST_DELAY) && (delay_cnt_r == 16'h0000);
  wire full_rst  = soft_fire || lv_trip || (dog_ovf && !low_power_i);

  always @(posedge clock_i) begin
    if (!nrst_i) begin
      dog_ctrl_r        <= `WDRC_DOG_CTRL_RST;
      brownout_r        <= `WDRC_BROWNOUT_RST;
      cause_r           <= 3'h0;
      dog_expiry_flag_r <= 1'b0;
      power_down_flag_r <= 1'b0;
      dog_cnt_r         <= 16'h0000;
      state_r           <= ST_RUN;
      delay_cnt_r       <= 16'h0000;
      pend_key_r        <= 1'b0;
      pend_lvl_r        <= 1'b0;
      deb_cnt_r         <= 16'h0000;
      sys_rst_r         <= 1'b0;
      pcsp_rst_r        <= 1'b0;
      por_r             <= 1'b1;
    end else begin
      por_r      <= 1'b0;
      sys_rst_r  <= full_rst;
      pcsp_rst_r <= dog_ovf && low_power_i;

      // Watchdog counter advances on slow ticks only.
      if (key_bad_wr || clr_dog_i || halt_i || full_rst || dog_ovf || !dog_enabled) begin
        dog_cnt_r <= 16'h0000;
      end else if (slow_tick_i) begin
        dog_cnt_r <= dog_cnt_r + 16'h0001;
      end

      if (lowvolt_en_o && supply_low_i && !lv_trip) begin
        deb_cnt_r <= deb_cnt_r + 16'h0001;
      end else begin
        deb_cnt_r <= 16'h0000;
      end

      // Soft reset delay after a bad key or level.
      case (state_r)
        ST_RUN: begin
          if (key_bad_wr || lvl_bad_wr) begin
            state_r     <= ST_DELAY;
            delay_cnt_r <= SOFT_DELAY_CYC[15:0] - 16'h0001;
            pend_key_r  <= key_bad_wr;
            pend_lvl_r  <= lvl_bad_wr;
          end
        end
        ST_DELAY: begin
          if (delay_cnt_r == 16'h0000) begin
            state_r <= ST_RUN;
          end else begin
            delay_cnt_r <= delay_cnt_r - 16'h0001;
          end
          pend_key_r <= pend_key_r || key_bad_wr;
          pend_lvl_r <= pend_lvl_r || lvl_bad_wr;
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase

      if (soft_fire && pend_key_r) begin
        dog_ctrl_r <= `WDRC_DOG_CTRL_RST;
      end else if (wr_dog) begin
        dog_ctrl_r <= wdata_i;
      end

      // Invalid level restores the power-on level; a genuine low supply keeps it.
      if (soft_fire && pend_lvl_r) begin
        brownout_r <= `WDRC_BROWNOUT_RST;
      end else if (wr_lvl) begin
        brownout_r <= wdata_i;
      end

      // Hardware sets win over software clears; only zero writes clear.
      cause_r[`WDRC_BIT_KEY_FAULT] <= (soft_fire && pend_key_r) ||
        (cause_r[`WDRC_BIT_KEY_FAULT] && !(wr_cause && !wdata_i[`WDRC_BIT_KEY_FAULT]));
      cause_r[`WDRC_BIT_LVL_FAULT] <= (soft_fire && pend_lvl_r) ||
        (cause_r[`WDRC_BIT_LVL_FAULT] && !(wr_cause && !wdata_i[`WDRC_BIT_LVL_FAULT]));
      cause_r[`WDRC_BIT_LOWVOLT] <= lv_trip ||
        (cause_r[`WDRC_BIT_LOWVOLT] && !(wr_cause && !wdata_i[`WDRC_BIT_LOWVOLT]));

      if (dog_ovf) begin
        dog_expiry_flag_r <= 1'b1;
      end else if (halt_i || clr_dog_i) begin
        dog_expiry_flag_r <= 1'b0;
      end

      if (halt_i) begin
        power_down_flag_r <= 1'b1;
      end else if (clr_dog_i) begin
        power_down_flag_r <= 1'b0;
      end
    end
  end

  always @(posedge clock_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `WDRC_OFS_DOG_CTRL: rdata_o <= dog_ctrl_r;
        `WDRC_OFS_CAUSE:    rdata_o <= {5'h00, cause_r};
        `WDRC_OFS_BROWNOUT: rdata_o <= brownout_r;
        `WDRC_OFS_STATUS:   rdata_o <= {6'h00, power_down_flag_r, dog_expiry_flag_r};
        default:            rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // The core clears its program counter on either reset output.
  assign sys_reset_o      = sys_rst_r;
  assign pc_sp_reset_o    = pcsp_rst_r | sys_rst_r;
  assign port_preset_o    = por_r;
  assign port_reset_val_o = `WDRC_PORT_RST;
  assign brownout_level_o = brownout_r;

endmodule

// ==== wdrc_props.sv ====
// Port assertions for the watchdog and reset block.
// Assumes short test delays: soft delay and debounce of a few cycles.
`timescale 1ns/1ps
module wdrc_props (
  input wire       clock_i, nrst_i, wr_i, rd_i, low_power_i, supply_low_i,
  input wire       sys_reset_o, pc_sp_reset_o, lowvolt_en_o,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i, rdata_o, brownout_level_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence bad_key;
    wr_i && addr_i == 4'h0 && wdata_i[7:3] != 5'h0A && wdata_i[7:3] != 5'h15;
  endsequence
  sequence bad_lvl;
    wr_i && addr_i == 4'h2 && wdata_i != 8'h5A && wdata_i != 8'hA5;
  endsequence
  sequence short_dip;
    !supply_low_i ##1 supply_low_i [*2] ##1 !supply_low_i;
  endsequence
  a_key_reset: assert property (bad_key |-> ##[1:40] sys_reset_o)
    else $error("bad key gave no reset");
  a_lvl_reset: assert property (bad_lvl |-> ##[1:40] sys_reset_o)
    else $error("bad level gave no reset");
  a_lvl_reload: assert property (bad_lvl ##[1:40] sys_reset_o |->
    ##[0:2] brownout_level_o == 8'h5A) else $error("level not reloaded");
  a_reset_pulse: assert property (sys_reset_o |-> pc_sp_reset_o ##1 !sys_reset_o)
    else $error("reset pulse malformed");
  a_detect_sleep: assert property (low_power_i |-> !lowvolt_en_o)
    else $error("detection armed in sleep");
  a_short_dip: assert property (short_dip |-> !sys_reset_o [*3])
    else $error("short dip caused reset");
  a_long_dip: assert property ($rose(supply_low_i) ##1
    (supply_low_i && lowvolt_en_o) [*4] |-> ##[0:3] sys_reset_o) else $error("long dip ignored");
  a_cause_upper: assert property (rd_i && addr_i == 4'h1 |=> rdata_o[7:3] == 5'h00)
    else $error("cause upper bits set");
endmodule
bind wdrc_watchdog_and_reset_control wdrc_props u_props (.*);

// ==== wdrc_watchdog_and_reset_control_test.sv ====
// Self-checking bench for the watchdog and reset block.
// Assumes the checker binds itself; the bench drives every port.
`timescale 1ns/1ps
module wdrc_watchdog_and_reset_control_test;
  logic        clock_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, slow_tick_i = 1'b0;
  logic        clr_dog_i = 1'b0, halt_i = 1'b0, low_power_i = 1'b0, supply_low_i = 1'b0;
  logic        tick_on = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wdata_i = 8'h00;
  wire  [7:0]  rdata_o, port_reset_val_o, brownout_level_o;
  wire         sys_reset_o, pc_sp_reset_o, port_preset_o, lowvolt_en_o;
  int          n_mismatch = 0, num_checks = 0, ticks = 0;
  logic [20:0] rows [11] = '{{1'b0, 4'h0, 8'h00, 8'h53}, {1'b0, 4'h2, 8'h00, 8'h5A},
    {1'b0, 4'h1, 8'h00, 8'h00}, {1'b0, 4'h3, 8'h00, 8'h00}, {1'b1, 4'h0, 8'h57, 8'h57},
    {1'b1, 4'h0, 8'hA8, 8'hA8}, {1'b1, 4'h2, 8'hA5, 8'hA5}, {1'b1, 4'h2, 8'h5A, 8'h5A},
    {1'b1, 4'h1, 8'hFF, 8'h00}, {1'b1, 4'h4, 8'hFF, 8'h00}, {1'b1, 4'h0, 8'h53, 8'h53}};
  always #20 clock_i = ~clock_i;
  // Ticks every other cycle so the slow count source differs from the clock.
  always @(posedge clock_i) slow_tick_i <= tick_on & ~slow_tick_i;
  wdrc_watchdog_and_reset_control #(.SOFT_DELAY_CYC(2), .DEBOUNCE_CYC(3)) DUT (.*);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(what, exp, rdata_o);
  endtask
  task automatic wait_for(input bit pcsp, input int lim);
    int i;
    for (i = 0; i < lim && (pcsp ? pc_sp_reset_o : sys_reset_o) !== 1'b1; i++) @(negedge clock_i);
    if (i == lim) begin
      n_mismatch++;
      $display("Error reset pulse: expected 1, seen 0");
      give_verdict;
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    chk("port value", 8'hFF, port_reset_val_o);
    foreach (rows[i]) begin
      if (rows[i][20]) wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16], rows[i][7:0], "register");
    end
    $display("Register table test done");
    wr(4'h0, 8'hFB);
    wait_for(0, 40);
    rd(4'h1, 8'h01, "key fault");
    rd(4'h0, 8'h53, "ctrl reload");
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h00, "fault clear");
    wr(4'h2, 8'h12);
    wait_for(0, 40);
    rd(4'h1, 8'h02, "level fault");
    rd(4'h2, 8'h5A, "level reload");
    wr(4'h1, 8'h00);
    $display("Bad key tests done");
    supply_low_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    supply_low_i <= 1'b0;
    rd(4'h1, 8'h00, "short dip");
    supply_low_i <= 1'b1;
    wait_for(0, 20);
    supply_low_i <= 1'b0;
    rd(4'h1, 8'h04, "low supply");
    rd(4'h2, 8'h5A, "level kept");
    wr(4'h1, 8'h00);
    $display("Supply tests done");
    wr(4'h0, 8'h50);
    tick_on <= 1'b1;
    for (int i = 0; i < 1200 && sys_reset_o !== 1'b1; i++) begin
      @(negedge clock_i);
      ticks += slow_tick_i;
    end
    chk("tick count", 8'h01, {7'h00, ticks >= 255 && ticks <= 257});
    rd(4'h3, 8'h01, "expiry flag");
    wr(4'h0, 8'h50);
    halt_i <= 1'b1;
    low_power_i <= 1'b1;
    @(posedge clock_i);
    halt_i <= 1'b0;
    wait_for(1, 1200);
    chk("full reset", 8'h00, {7'h00, sys_reset_o});
    low_power_i <= 1'b0;
    rd(4'h3, 8'h03, "sleep flags");
    clr_dog_i <= 1'b1;
    @(posedge clock_i);
    clr_dog_i <= 1'b0;
    tick_on <= 1'b0;
    rd(4'h3, 8'h00, "flags cleared");
    $display("Watchdog tests done");
    // Service the watchdog every 300 cycles, about 150 ticks, well inside the 256-tick period.
    tick_on <= 1'b1;
    ticks = 0;
    repeat (4) begin
      repeat (300) begin
        @(negedge clock_i);
        ticks += sys_reset_o;
      end
      clr_dog_i <= 1'b1;
      @(posedge clock_i);
      clr_dog_i <= 1'b0;
    end
    chk("serviced dog resets", 8'h00, ticks[7:0]);
    tick_on <= 1'b0;
    $display("Service test done");
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 chk("preset in reset", 8'h01, {7'h00, port_preset_o});
    nrst_i <= 1'b1;
    @(posedge clock_i);
    #1 chk("preset after reset", 8'h00, {7'h00, port_preset_o});
    rd(4'h0, 8'h53, "ctrl after reset");
    rd(4'h3, 8'h00, "status after reset");
    $display("Reset test done");
    give_verdict;
  end
endmodule
